/* rfid_reader_config_registers.sv */
// Configuration register bank with protocol presets, host word decoder and transmit FIFO
`timescale 1ns/1ns
module rfid_reader_config_registers (
  input  logic                    MCLK,
  input  logic                    RESETN,
  input  logic                    CE,
  input  logic                    EN,
  input  logic                    HOST_CS,
  input  rfid_cfg_pkg::host_req_t HOST_REQ,
  output rfid_cfg_pkg::host_ans_t HOST_ANS,
  output logic                    CMD_STROBE,
  output logic [4:0]              CMD_CODE,
  input  logic [7:0]              IRQ_STATUS,
  input  logic [7:0]              SIGNAL_LEVEL_OSC_STATUS,
  input  logic                    COLL_LOAD,
  input  logic [7:0]              COLL_POS,
  input  logic                    TX_POP,
  output logic [7:0]              TX_BYTE,
  output logic                    TX_VALID,
  output logic                    TX_AVAIL,
  output logic [7:0]              PROTOCOL,
  output logic                    DIRECT_MODE_TYPE,
  output logic                    STANDBY,
  output logic                    ACTIVE_READY,
  output logic                    DIRECT_MODE,
  output logic                    TRANSMITTER_ENABLE,
  output logic                    RECEIVER_ENABLE,
  output logic                    OSC_FORCE,
  output logic                    HALF_POWER_SELECT,
  output logic                    AUX_INPUT_SELECT,
  output logic                    SUPPLY_RANGE_SELECT,
  output logic                    CLOCK_OUT_SEL_LOW,
  output logic                    CLOCK_OUT_SEL_HIGH
);
  import rfid_cfg_pkg::*;

  function automatic preset_t preset_of(input logic [7:0] p);
    preset_t r;
    r = PRESET_OTHER;
    case (p[4:2])
      3'b000, 3'b001: r = PRESET_VICINITY;
      3'b010:         r = PRESET_TYPE_A;
      3'b011:         r = PRESET_TYPE_B;
      default:        r = PRESET_OTHER;
    endcase
    return r;
  endfunction

  // Clock output bits are passed in so a reload can keep them
  function automatic logic [11:0][7:0] load_presets(input logic [11:0][7:0] c, input logic [7:0] p);
    logic [11:0][7:0] r;
    preset_t          pre;
    r   = c;
    pre = preset_of(p);
    for (int i = 0; i < 10; i++) begin
      r[i+2] = pre[i];
    end
    r[ADDR_MOD_CLK[3:0]] = (pre[7] & ~CLO_MASK) | (c[ADDR_MOD_CLK[3:0]] & CLO_MASK);
    return r;
  endfunction

  function automatic state_t default_state();
    state_t s;
    s           = '0;
    s.phase     = PH_FIRST;
    s.cfg[0]    = CSC_RESET;
    s.cfg[1]    = PROTO_RESET;
    s.cfg       = load_presets(s.cfg, PROTO_RESET);
    return s;
  endfunction

  localparam state_t STATE_RESET = default_state();

  state_t     q;
  state_t     d;
  logic       take;
  logic       first_cmd;
  logic       acc_en;
  logic       acc_wr;
  logic [4:0] acc_addr;
  logic [7:0] rd_val;
  logic       push_ok;
  logic       host_pop;
  logic       tx_pop_ok;
  logic       wr_proto;
  logic       wr_csc;
  logic       leave_stby;
  logic       fifo_clear;
  logic       soft_init;
  preset_t    pre_new;

  assign take      = CE & q.en_s2 & HOST_CS & HOST_REQ.valid;
  assign first_cmd = (q.phase == PH_FIRST) & HOST_REQ.data[W_CMD];
  // A read is served straight from the address word; writes wait for the data word
  assign acc_en    = take & ((q.phase == PH_DATA) | (~first_cmd & HOST_REQ.data[W_READ]));
  assign acc_wr    = (q.phase == PH_DATA) & ~q.rw;
  assign acc_addr  = (q.phase == PH_FIRST) ? HOST_REQ.data[4:0] : q.addr;
  assign wr_proto  = acc_en & acc_wr & (acc_addr == ADDR_PROTO);
  assign wr_csc    = acc_en & acc_wr & (acc_addr == ADDR_CSC);
  assign leave_stby = wr_csc & q.cfg[0][CSC_STBY] & ~HOST_REQ.data[CSC_STBY];
  assign push_ok   = acc_en & acc_wr & (acc_addr == ADDR_FIFO) & (q.count != 4'(FIFO_DEPTH));
  assign host_pop  = acc_en & ~acc_wr & (acc_addr == ADDR_FIFO) & (q.count != 4'h0);
  // Host reads take the FIFO head first; the framer simply waits a cycle
  assign tx_pop_ok = CE & q.en_s2 & TX_POP & (q.count != 4'h0) & ~host_pop;
  assign fifo_clear = take & first_cmd & (HOST_REQ.data[4:0] == CMD_FIFO_RESET);
  assign soft_init = take & first_cmd & (HOST_REQ.data[4:0] == CMD_SOFT_INIT);
  assign pre_new   = preset_of(HOST_REQ.data);

  always_comb begin
    rd_val = 8'h00;
    case (acc_addr)
      ADDR_IRQ:       rd_val = IRQ_STATUS;
      ADDR_COLL_MASK: rd_val = q.coll_mask;
      ADDR_COLL_POS:  rd_val = q.coll_pos;
      ADDR_RSSI:      rd_val = SIGNAL_LEVEL_OSC_STATUS;
      ADDR_TEST_A:    rd_val = q.test_a;
      ADDR_TEST_B:    rd_val = q.test_b;
      ADDR_FIFO_STAT: rd_val = {3'h0, q.ovf, q.count};
      ADDR_LEN1:      rd_val = q.len1;
      ADDR_LEN2:      rd_val = q.len2;
      ADDR_FIFO:      rd_val = (q.count != 4'h0) ? q.fifo[q.rptr] : 8'h00;
      default: begin
        if (acc_addr <= ADDR_LOW_LAST) begin
          rd_val = q.cfg[acc_addr[3:0]];
        end else begin
          rd_val = 8'h00;
        end
      end
    endcase
  end

  always_comb begin
    d           = q;
    d.en_s1     = EN;
    d.en_s2     = q.en_s1;
    d.rvalid    = 1'b0;
    d.cmd_pulse = 1'b0;
    d.tx_valid  = 1'b0;
    if (q.startup != 10'h000) begin
      d.startup = 10'(q.startup - 10'h001);
    end
    if (take) begin
      case (q.phase)
        PH_FIRST: begin
          if (first_cmd) begin
            if (!fifo_clear && !soft_init) begin
              d.cmd_pulse = 1'b1;
              d.cmd_code  = HOST_REQ.data[4:0];
            end
          end else begin
            d.rw    = HOST_REQ.data[W_READ];
            d.cont  = HOST_REQ.data[W_CONT];
            d.addr  = HOST_REQ.data[4:0];
            if (HOST_REQ.data[W_READ]) begin
              d.addr  = HOST_REQ.data[W_CONT] ? 5'(HOST_REQ.data[4:0] + 5'h01) : HOST_REQ.data[4:0];
              d.phase = HOST_REQ.data[W_CONT] ? PH_DATA : PH_FIRST;
            end else begin
              d.phase = PH_DATA;
            end
          end
        end
        PH_DATA: begin
          if (q.cont) begin
            d.addr = 5'(q.addr + 5'h01);
          end else begin
            d.phase = PH_FIRST;
          end
        end
        default: d.phase = PH_FIRST;
      endcase
    end
    if (acc_en && !acc_wr) begin
      d.rdata  = rd_val;
      d.rvalid = 1'b1;
    end
    if (acc_en && acc_wr) begin
      case (acc_addr)
        ADDR_CSC: begin
          d.cfg[0] = HOST_REQ.data & CSC_WMASK;
          if (leave_stby) begin
            d.startup = STARTUP_COUNT;
          end
        end
        ADDR_PROTO: begin
          d.cfg[1] = HOST_REQ.data;
          d.cfg    = load_presets(d.cfg, HOST_REQ.data);
        end
        ADDR_COLL_MASK: d.coll_mask = HOST_REQ.data;
        ADDR_TEST_A:    d.test_a = HOST_REQ.data;
        ADDR_TEST_B:    d.test_b = HOST_REQ.data;
        ADDR_LEN1:      d.len1 = HOST_REQ.data;
        ADDR_LEN2:      d.len2 = HOST_REQ.data;
        ADDR_FIFO: begin
          if (push_ok) begin
            d.fifo[q.wptr] = HOST_REQ.data;
            d.wptr = (q.wptr == 4'(FIFO_DEPTH - 1)) ? 4'h0 : 4'(q.wptr + 4'h1);
          end else begin
            d.ovf = 1'b1;
          end
        end
        default: begin
          if (acc_addr >= ADDR_LOW_FIRST && acc_addr <= ADDR_LOW_LAST) begin
            d.cfg[acc_addr[3:0]] = HOST_REQ.data;
          end
        end
      endcase
    end
    if (host_pop || tx_pop_ok) begin
      d.rptr = (q.rptr == 4'(FIFO_DEPTH - 1)) ? 4'h0 : 4'(q.rptr + 4'h1);
    end
    if (tx_pop_ok) begin
      d.tx_byte  = q.fifo[q.rptr];
      d.tx_valid = 1'b1;
    end
    d.count = 4'(q.count + {3'h0, push_ok} - {3'h0, host_pop | tx_pop_ok});
    if (fifo_clear) begin
      d.fifo     = '0;
      d.wptr     = 4'h0;
      d.rptr     = 4'h0;
      d.count    = 4'h0;
      d.ovf      = 1'b0;
      d.coll_pos = 8'h00;
    end
    // A capture in the clearing cycle is kept
    if (COLL_LOAD) begin
      d.coll_pos = COLL_POS;
    end
    if (!HOST_CS) begin
      d.phase = PH_FIRST;
    end
    if (soft_init || !q.en_s2) begin
      d       = default_state();
      d.en_s1 = EN;
      d.en_s2 = q.en_s1;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= STATE_RESET;
    end else if (CE) begin
      q <= d;
    end
  end

  assign HOST_ANS.valid      = q.rvalid;
  assign HOST_ANS.data       = q.rdata;
  assign CMD_STROBE          = q.cmd_pulse;
  assign CMD_CODE            = q.cmd_code;
  assign TX_BYTE             = q.tx_byte;
  assign TX_VALID            = q.tx_valid;
  assign TX_AVAIL            = (q.count != 4'h0);
  assign PROTOCOL            = q.cfg[1];
  // Direct mode type is only meaningful once the host has set it ahead of the direct bit
  assign DIRECT_MODE_TYPE    = q.cfg[1][PROTO_DIRECT_TYPE];
  assign STANDBY             = q.cfg[0][CSC_STBY];
  assign ACTIVE_READY        = ~q.cfg[0][CSC_STBY] & (q.startup == 10'h000);
  assign DIRECT_MODE         = q.cfg[0][CSC_DIRECT];
  assign TRANSMITTER_ENABLE  = q.cfg[0][CSC_TRANSMITTER_ENABLE];
  assign RECEIVER_ENABLE     = q.cfg[0][CSC_TRANSMITTER_ENABLE] | q.cfg[0][CSC_REC_ON];
  assign OSC_FORCE           = q.cfg[0][CSC_REC_ON];
  assign HALF_POWER_SELECT   = q.cfg[0][CSC_HALF];
  assign AUX_INPUT_SELECT    = q.cfg[0][CSC_AUX];
  assign SUPPLY_RANGE_SELECT = q.cfg[0][CSC_SUPPLY];
  assign CLOCK_OUT_SEL_LOW   = q.cfg[ADDR_MOD_CLK[3:0]][CLO_LOW];
  assign CLOCK_OUT_SEL_HIGH  = q.cfg[ADDR_MOD_CLK[3:0]][CLO_HIGH];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_rsvd_zero;
    q.cfg[0][CSC_RSVD] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bit set");

  property p_en_low_default;
    (CE && !q.en_s2) |=> (q.cfg[0] == CSC_RESET) && (q.cfg[1] == PROTO_RESET) && (q.cfg[2] == PRESET_VICINITY[0]);
  endproperty
  a_en_low_default: assert property (p_en_low_default) else $error("enable low did not restore defaults");

  property p_proto_reload;
    (wr_proto && !soft_init) |=> (q.cfg[3] == $past(pre_new[1])) && (q.cfg[8] == $past(pre_new[6]))
                                && (q.cfg[11] == $past(pre_new[9]));
  endproperty
  a_proto_reload: assert property (p_proto_reload) else $error("presets not reloaded");

  property p_clo_kept;
    wr_proto |=> (q.cfg[ADDR_MOD_CLK[3:0]] & CLO_MASK) == ($past(q.cfg[ADDR_MOD_CLK[3:0]]) & CLO_MASK);
  endproperty
  a_clo_kept: assert property (p_clo_kept) else $error("clock output select lost on reload");

  property p_startup;
    leave_stby |=> (!ACTIVE_READY || !q.en_s2)[*8];
  endproperty
  a_startup: assert property (p_startup) else $error("ready too early after standby");

  property p_rx_follow;
    // Checked against the written byte so a wrong output equation cannot pass
    wr_csc |=> RECEIVER_ENABLE == ($past(HOST_REQ.data[CSC_TRANSMITTER_ENABLE]) || $past(HOST_REQ.data[CSC_REC_ON]));
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receiver enable wrong");

  property p_unmapped_zero;
    (acc_en && !acc_wr && acc_addr >= ADDR_UNMAP_FIRST && acc_addr <= ADDR_UNMAP_LAST && !soft_init)
      |=> HOST_ANS.valid && (HOST_ANS.data == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_fifo_reset;
    (fifo_clear && !COLL_LOAD) |=> (q.count == 4'h0) && !TX_AVAIL && (q.coll_pos == 8'h00) && !q.ovf;
  endproperty
  a_fifo_reset: assert property (p_fifo_reset) else $error("fifo reset incomplete");

  property p_mask_readback;
    (acc_en && acc_wr && acc_addr == ADDR_COLL_MASK) ##1 (acc_en && !acc_wr && acc_addr == ADDR_COLL_MASK && CE)
      |=> HOST_ANS.data == $past(q.coll_mask);
  endproperty
  a_mask_readback: assert property (p_mask_readback) else $error("mask register readback wrong");

  property p_cmd_decode;
    (take && first_cmd && !fifo_clear && !soft_init) |=> CMD_STROBE && (CMD_CODE == $past(HOST_REQ.data[4:0]));
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("command word not decoded");

  property p_read_answer;
    (acc_en && !acc_wr) |=> HOST_ANS.valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");

  // A frozen clock enable must hold every register, answer pulses included
  property p_ce_freeze;
    !CE |=> $stable(q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  property p_csc_write;
    wr_csc |=> q.cfg[0] == ($past(HOST_REQ.data) & CSC_WMASK);
  endproperty
  a_csc_write: assert property (p_csc_write) else $error("status control write not stored");

  property p_csc_pins;
    wr_csc |=> (STANDBY == $past(HOST_REQ.data[CSC_STBY]))
               && (DIRECT_MODE == $past(HOST_REQ.data[CSC_DIRECT]))
               && (HALF_POWER_SELECT == $past(HOST_REQ.data[CSC_HALF]))
               && (AUX_INPUT_SELECT == $past(HOST_REQ.data[CSC_AUX]))
               && (SUPPLY_RANGE_SELECT == $past(HOST_REQ.data[CSC_SUPPLY]));
  endproperty
  a_csc_pins: assert property (p_csc_pins) else $error("status control pins wrong");

  property p_tx_enable;
    wr_csc |=> TRANSMITTER_ENABLE == $past(HOST_REQ.data[CSC_TRANSMITTER_ENABLE]);
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("transmitter enable wrong");

  property p_soft_init;
    soft_init |=> (q.cfg[0] == CSC_RESET) && (q.cfg[1] == PROTO_RESET) && !CLOCK_OUT_SEL_LOW && !CLOCK_OUT_SEL_HIGH;
  endproperty
  a_soft_init: assert property (p_soft_init) else $error("software init did not restore defaults");

  c_proto_write: cover property (wr_proto ##1 CE ##1 (acc_en && acc_wr && acc_addr == ADDR_LOW_FIRST));
  c_fifo_reset:  cover property (push_ok ##[1:10] fifo_clear);
  c_cont_read:   cover property ((take && q.phase == PH_DATA && q.rw && q.cont) [*3]);
  c_leave_stby:  cover property (leave_stby);
  c_soft_init:   cover property (soft_init);

endmodule

/* rfid_cfg_pkg.sv */
// Constants, carrier types and state layout for the reader configuration register bank
package rfid_cfg_pkg;

  localparam int FIFO_DEPTH = 12;

  localparam logic [4:0] ADDR_CSC         = 5'h00;
  localparam logic [4:0] ADDR_PROTO       = 5'h01;
  localparam logic [4:0] ADDR_LOW_FIRST   = 5'h02;
  localparam logic [4:0] ADDR_MOD_CLK     = 5'h09;
  localparam logic [4:0] ADDR_LOW_LAST    = 5'h0B;
  localparam logic [4:0] ADDR_IRQ         = 5'h0C;
  localparam logic [4:0] ADDR_COLL_MASK   = 5'h0D;
  localparam logic [4:0] ADDR_COLL_POS    = 5'h0E;
  localparam logic [4:0] ADDR_RSSI        = 5'h0F;
  localparam logic [4:0] ADDR_UNMAP_FIRST = 5'h10;
  localparam logic [4:0] ADDR_UNMAP_LAST  = 5'h19;
  localparam logic [4:0] ADDR_TEST_A      = 5'h1A;
  localparam logic [4:0] ADDR_TEST_B      = 5'h1B;
  localparam logic [4:0] ADDR_FIFO_STAT   = 5'h1C;
  localparam logic [4:0] ADDR_LEN1        = 5'h1D;
  localparam logic [4:0] ADDR_LEN2        = 5'h1E;
  localparam logic [4:0] ADDR_FIFO        = 5'h1F;

  // First host word layout
  localparam int W_CMD  = 7;
  localparam int W_READ = 6;
  localparam int W_CONT = 5;

  localparam logic [4:0] CMD_SOFT_INIT  = 5'h03;
  localparam logic [4:0] CMD_FIFO_RESET = 5'h0F;

  // Chip status control fields
  localparam int CSC_STBY   = 7;
  localparam int CSC_DIRECT = 6;
  localparam int CSC_TRANSMITTER_ENABLE  = 5;
  localparam int CSC_HALF   = 4;
  localparam int CSC_AUX    = 3;
  localparam int CSC_RSVD   = 2;
  localparam int CSC_REC_ON = 1;
  localparam int CSC_SUPPLY = 0;
  localparam logic [7:0] CSC_RESET = 8'h01;
  localparam logic [7:0] CSC_WMASK = 8'hFB;

  localparam logic [7:0] PROTO_RESET       = 8'h02;
  localparam int         PROTO_DIRECT_TYPE = 6;

  // Clock output select bits in the modulator register
  localparam int         CLO_LOW  = 4;
  localparam int         CLO_HIGH = 5;
  localparam logic [7:0] CLO_MASK = 8'h30;

  localparam int FSTAT_OVF = 4;

  // Preset images for 0x02..0x0B, entry 0 is 0x02
  typedef logic [9:0][7:0] preset_t;
  localparam preset_t PRESET_VICINITY = {8'h01, 8'h10, 8'h01, 8'h1F, 8'h0E, 8'hC1, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam preset_t PRESET_TYPE_A   = {8'h01, 8'h20, 8'h21, 8'h07, 8'h0E, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam preset_t PRESET_TYPE_B   = {8'h01, 8'h20, 8'h20, 8'h07, 8'h0E, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam preset_t PRESET_OTHER    = {8'h01, 8'h40, 8'h22, 8'h07, 8'h1C, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam int         STARTUP_TIME_NS = 100000;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STARTUP_COUNT   = 10'(STARTUP_CYCLES);

  typedef enum logic [1:0] {
    PH_FIRST = 2'b01,
    PH_DATA  = 2'b10
  } phase_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } host_ans_t;

  typedef struct packed {
    logic                        en_s1;
    logic                        en_s2;
    logic [11:0][7:0]            cfg;
    logic [7:0]                  coll_mask;
    logic [7:0]                  coll_pos;
    logic [7:0]                  test_a;
    logic [7:0]                  test_b;
    logic [7:0]                  len1;
    logic [7:0]                  len2;
    logic [FIFO_DEPTH-1:0][7:0]  fifo;
    logic [3:0]                  wptr;
    logic [3:0]                  rptr;
    logic [3:0]                  count;
    logic                        ovf;
    phase_t                      phase;
    logic [4:0]                  addr;
    logic                        rw;
    logic                        cont;
    logic [7:0]                  rdata;
    logic                        rvalid;
    logic                        cmd_pulse;
    logic [4:0]                  cmd_code;
    logic [9:0]                  startup;
    logic [7:0]                  tx_byte;
    logic                        tx_valid;
  } state_t;

endpackage

/* rfid_host_model.sv */
// Host microcontroller model that drives the register port of the reader
`timescale 1ns/1ns
module rfid_host_model (
  input  logic                    MCLK,
  output logic                    HOST_CS,
  output rfid_cfg_pkg::host_req_t HOST_REQ
);
  import rfid_cfg_pkg::*;

  initial begin
    HOST_CS  = 1'b0;
    HOST_REQ = '0;
  end

  // Each byte stays put for a whole cycle, so the edge that takes it sees it stable
  task send(input logic [7:0] b);
    @(posedge MCLK);
    #10;
    HOST_CS        = 1'b1;
    HOST_REQ.valid = 1'b1;
    HOST_REQ.data  = b;
  endtask

  // Released data is inverted so that a stale byte can never pass for a fresh one
  task finish();
    @(posedge MCLK);
    #10;
    HOST_REQ.valid = 1'b0;
    HOST_REQ.data  = ~HOST_REQ.data;
    HOST_CS        = 1'b0;
  endtask
endmodule

/* rfid_reader_config_registers_tb.sv */
// Self-checking testbench for the reader configuration register bank
`timescale 1ns/1ns
module rfid_reader_config_registers_tb;
  import rfid_cfg_pkg::*;
  logic       MCLK = 1'b0, RESETN = 1'b0, CE = 1'b1, EN = 1'b1, COLL_LOAD = 1'b0, TX_POP = 1'b0, HOST_CS;
  logic [7:0] IRQ_STATUS = 8'h5A, SIGNAL_LEVEL_OSC_STATUS = 8'hA5, COLL_POS = 8'h00;
  host_req_t  HOST_REQ;
  host_ans_t  HOST_ANS;
  logic       CMD_STROBE, TX_VALID, TX_AVAIL, DIRECT_MODE_TYPE, STANDBY, ACTIVE_READY, DIRECT_MODE;
  logic       TRANSMITTER_ENABLE, RECEIVER_ENABLE, OSC_FORCE, HALF_POWER_SELECT, AUX_INPUT_SELECT;
  logic       SUPPLY_RANGE_SELECT, CLOCK_OUT_SEL_LOW, CLOCK_OUT_SEL_HIGH;
  logic [4:0] CMD_CODE;
  logic [7:0] TX_BYTE, PROTOCOL, v, w;
  logic [7:0] exp_q[$];
  logic [7:0] pr[4];
  preset_t    ps[4];
  int         n_mismatch = 0, checks_done = 0, cycles = 0, seed = 12;

  rfid_reader_config_registers i_dut (
    .MCLK(MCLK), .RESETN(RESETN), .CE(CE), .EN(EN), .HOST_CS(HOST_CS), .HOST_REQ(HOST_REQ),
    .HOST_ANS(HOST_ANS), .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .IRQ_STATUS(IRQ_STATUS),
    .SIGNAL_LEVEL_OSC_STATUS(SIGNAL_LEVEL_OSC_STATUS), .COLL_LOAD(COLL_LOAD), .COLL_POS(COLL_POS), .TX_POP(TX_POP),
    .TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID), .TX_AVAIL(TX_AVAIL), .PROTOCOL(PROTOCOL),
    .DIRECT_MODE_TYPE(DIRECT_MODE_TYPE), .STANDBY(STANDBY), .ACTIVE_READY(ACTIVE_READY),
    .DIRECT_MODE(DIRECT_MODE), .TRANSMITTER_ENABLE(TRANSMITTER_ENABLE),
    .RECEIVER_ENABLE(RECEIVER_ENABLE), .OSC_FORCE(OSC_FORCE), .HALF_POWER_SELECT(HALF_POWER_SELECT),
    .AUX_INPUT_SELECT(AUX_INPUT_SELECT), .SUPPLY_RANGE_SELECT(SUPPLY_RANGE_SELECT),
    .CLOCK_OUT_SEL_LOW(CLOCK_OUT_SEL_LOW), .CLOCK_OUT_SEL_HIGH(CLOCK_OUT_SEL_HIGH)
  );

  rfid_host_model i_host (
    .MCLK(MCLK), .HOST_CS(HOST_CS), .HOST_REQ(HOST_REQ)
  );

  always #50 MCLK = ~MCLK;

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    i_host.send({3'b000, a});
    i_host.send(d);
    i_host.finish();
  endtask

  // The expected answer is noted before the byte goes out; the monitor pops it
  task rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.send({3'b010, a});
    i_host.finish();
  endtask

  // Continuous read of the ten low-level registers; dummy bytes are random
  task rd_run(input preset_t e);
    for (int i = 0; i < 10; i++) begin
      exp_q.push_back(e[i]);
      i_host.send(i == 0 ? {3'b011, ADDR_LOW_FIRST} : 8'($random(seed)));
    end
    i_host.finish();
  endtask

  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Answer monitor: sampled mid-cycle, away from the edge that launches it
  always @(negedge MCLK) begin
    if (HOST_ANS.valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unasked answer", 8'h00, 8'h01);
      else chk("read data", exp_q.pop_front(), HOST_ANS.data);
    end
  end

  initial begin
    repeat (2) @(posedge MCLK);
    #10 RESETN = 1'b1;
    repeat (4) @(posedge MCLK);
    #10;
    chk("reset pins", {6'h0, SUPPLY_RANGE_SELECT, ACTIVE_READY}, 8'h03);
    rd(ADDR_CSC, CSC_RESET);
    rd(ADDR_PROTO, PROTO_RESET);
    rd_run(PRESET_VICINITY);
    w = $random(seed);
    wr(ADDR_MOD_CLK, w);
    i_host.send(8'h24);
    i_host.send(8'h11);
    i_host.send(8'h22);
    i_host.finish();
    rd(5'h05, 8'h22);
    ps = '{PRESET_TYPE_A, PRESET_TYPE_B, PRESET_OTHER, PRESET_VICINITY};
    pr = '{8'h08, 8'h0C, 8'h1A, 8'h02};
    // Ending on the default protocol shows its presets come back; the custom values already went at the first reload
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_PROTO, pr[k]);
      chk("protocol pins", pr[k], PROTOCOL);
      ps[k][7] = (ps[k][7] & ~CLO_MASK) | (w & CLO_MASK);
      rd_run(ps[k]);
      chk("clock out", {6'h0, CLOCK_OUT_SEL_HIGH, CLOCK_OUT_SEL_LOW}, {6'h0, w[5:4]});
      rd(ADDR_PROTO, pr[k]);
    end
    wr(ADDR_PROTO, 8'h42);
    chk("direct type", {7'h0, DIRECT_MODE_TYPE}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h7F : (k == 1) ? 8'h00 : (8'($random(seed)) & 8'h7F);
      wr(ADDR_CSC, v);
      chk("csc pins", {STANDBY, DIRECT_MODE, TRANSMITTER_ENABLE, HALF_POWER_SELECT, AUX_INPUT_SELECT,
          1'b0, OSC_FORCE, SUPPLY_RANGE_SELECT}, v & CSC_WMASK);
      chk("receiver", {7'h0, RECEIVER_ENABLE}, {7'h0, v[5] | v[1]});
      rd(ADDR_CSC, v & CSC_WMASK);
    end
    wr(ADDR_CSC, 8'h80);
    chk("standby", {6'h0, STANDBY, ACTIVE_READY}, 8'h02);
    wr(ADDR_CSC, 8'h00);
    // Exact edge: one cycle before the count runs out the block must still be starting
    repeat (STARTUP_CYCLES - 1) @(posedge MCLK);
    #10;
    chk("startup", {7'h0, ACTIVE_READY}, 8'h00);
    @(posedge MCLK);
    #10;
    chk("startup done", {7'h0, ACTIVE_READY}, 8'h01);
    v = $random(seed);
    wr(ADDR_COLL_MASK, v);
    rd(ADDR_COLL_MASK, v);
    // Write then read in adjacent cycles within one frame
    v = $random(seed);
    exp_q.push_back(v);
    i_host.send({3'b000, ADDR_COLL_MASK});
    i_host.send(v);
    i_host.send({3'b010, ADDR_COLL_MASK});
    i_host.finish();
    // Freeze only after the answer pulse has gone, or it would stand for the whole freeze
    @(posedge MCLK);
    #10 CE = 1'b0;
    wr(ADDR_COLL_MASK, ~v);
    CE = 1'b1;
    rd(ADDR_COLL_MASK, v);
    for (int a = 16; a <= 25; a += 3) begin
      wr(5'(a), 8'hFF);
      rd(5'(a), 8'h00);
    end
    IRQ_STATUS  = 8'($random(seed));
    SIGNAL_LEVEL_OSC_STATUS = 8'($random(seed));
    rd(ADDR_IRQ, IRQ_STATUS);
    rd(ADDR_RSSI, SIGNAL_LEVEL_OSC_STATUS);
    @(posedge MCLK);
    #10 COLL_POS = 8'h3C;
    COLL_LOAD = 1'b1;
    @(posedge MCLK);
    #10 COLL_LOAD = 1'b0;
    wr(ADDR_COLL_POS, 8'h00);
    rd(ADDR_COLL_POS, 8'h3C);
    for (int k = 0; k < 3; k++) wr(ADDR_FIFO, 8'hA0 + 8'(k));
    rd(ADDR_FIFO_STAT, 8'h03);
    @(posedge MCLK);
    #10 TX_POP = 1'b1;
    @(posedge MCLK);
    #10 TX_POP = 1'b0;
    chk("tx byte", 8'hA0, TX_BYTE);
    chk("tx valid", {7'h0, TX_VALID}, 8'h01);
    rd(ADDR_FIFO_STAT, 8'h02);
    rd(ADDR_FIFO, 8'hA1);
    i_host.send(8'h8F);
    i_host.finish();
    rd(ADDR_FIFO_STAT, 8'h00);
    rd(ADDR_COLL_POS, 8'h00);
    chk("fifo avail", {7'h0, TX_AVAIL}, 8'h00);
    i_host.send(8'h91);
    i_host.finish();
    chk("command code", {3'h0, CMD_CODE}, 8'h11);
    chk("command strobe", {7'h0, CMD_STROBE}, 8'h01);
    wr(ADDR_PROTO, 8'h0C);
    i_host.send({3'b100, CMD_SOFT_INIT});
    i_host.finish();
    rd(ADDR_PROTO, PROTO_RESET);
    chk("clock out", {6'h0, CLOCK_OUT_SEL_HIGH, CLOCK_OUT_SEL_LOW}, 8'h00);
    wr(ADDR_CSC, 8'h25);
    EN = 1'b0;
    repeat (4) @(posedge MCLK);
    #10;
    chk("chip off pins", {6'h0, TRANSMITTER_ENABLE, SUPPLY_RANGE_SELECT}, 8'h01);
    EN = 1'b1;
    repeat (4) @(posedge MCLK);
    rd(ADDR_CSC, CSC_RESET);
    rd(ADDR_PROTO, PROTO_RESET);
    rd_run(PRESET_VICINITY);
    repeat (3) @(posedge MCLK);
    chk("answers left", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule
